//--- verilog/cssr_pkg.sv
// Summary of operation
// R01: rising shift edge samples input into MSB
// R02: shift toward LSB, byte after eight
// R03: full byte copied to buffer, full set
// R04: reading receive buffer clears full flag
// R05: overrun sets error flags, buffer kept
// R06: byte moved to buffer raises receive request
// R07: peer stops external clock after eight
// R08: external clock phases at least eight cycles
// R09: enable and buffer load while clock high
// R10: overrun cleared by disable or status write
// R11: shift complete falls half to 1.5 periods later
// R12: transmit disable stops clock, clears flags
// R13: port disable leaves transmitter running
// R14: receive disable resets shifter and flags
// R15: full duplex disables both together
// R16: disable, configure, then enable
// R17: transmit enable sets both transmit flags
// R18: switching to serial may raise requests
// R19: receiver sets all three for ready
// R20: falling edge drives LSB first
// R21: clock select: baud/4 or pin
// R22: buffer write lowers ready, first fall raises
// R23: everything zero after reset; sclk_out, txd_out and peer_ready_out_n reset high
package cssr_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_TBUF = 8'h08;
   localparam logic [7:0] OFS_RBUF = 8'h0c;
   localparam logic [7:0] OFS_BRG = 8'h10;
   localparam logic [7:0] OFS_IREQ = 8'h14;
   // control bit positions
   localparam int CR_SRC16 = 0;
   localparam int CR_MODE = 1;
   localparam int CR_CKS = 2;
   localparam int CR_RDYE = 3;
   localparam int CR_TXE = 4;
   localparam int CR_RXE = 5;
   localparam int CR_TIS = 6;
   localparam int CR_SEN = 7;
   // status bit positions
   localparam int SR_TBE = 0;
   localparam int SR_RBF = 1;
   localparam int SR_TSC = 2;
   localparam int SR_OVR = 3;
   localparam int SR_SUM = 6;
   // request bit positions
   localparam int IR_TX = 0;
   localparam int IR_RX = 1;
   // reset values and counts
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BRG_RST = 8'h00;
   localparam logic [3:0] PRE_DIV4 = 4'h3;
   localparam logic [3:0] PRE_DIV16 = 4'hf;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [2:0] RX_LAST = 3'h7;

   typedef enum logic {RUN_IDLE, RUN_SHIFT} cssr_run_t;

   typedef struct packed {
      logic s1;
      logic s2;
   } cssr_sync_t;

   typedef struct packed {
      logic [3:0] pre;
      logic [7:0] cnt;
      logic tick;
   } cssr_brg_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] brg;
      logic [7:0] tbuf;
      logic [7:0] tsr;
      logic [3:0] tcnt;
      logic tbe;
      logic tsc;
      logic [7:0] rbuf;
      logic [7:0] rsr;
      logic [2:0] rcnt;
      logic rbf;
      logic ovr;
      logic sum;
      logic irq_tx;
      logic irq_rx;
      cssr_run_t run;
      logic sclk_o;
      logic sclk_d;
      logic tph;
      logic txd;
      logic rdy_n;
      logic sclk_oe;
      logic txd_oe;
      logic rdy_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cssr_state_t;
endpackage : cssr_pkg

//--- verilog/cssr_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_sync2
   import cssr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   output logic q
);
   cssr_sync_t s_q;
   cssr_sync_t s_d;

   // second stage alone feeds the logic
   always_comb
   begin
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign q = s_q.s2;
endmodule : cssr_sync2
`default_nettype wire

//--- verilog/cssr_brg.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_brg
   import cssr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en,
   input wire logic src16,
   input wire logic [7:0] div,
   output logic tick
);
   cssr_brg_t s_q;
   cssr_brg_t s_d;
   logic [3:0] pre_top;

   // prescale by 4 or 16, then by div+1
   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      pre_top = src16 ? PRE_DIV16 : PRE_DIV4;
      if (!en)
      begin
         s_d.pre = 4'h0;
         s_d.cnt = div;
      end
      else if (s_q.pre == pre_top)
      begin
         s_d.pre = 4'h0;
         if (s_q.cnt == 8'h00)
         begin
            s_d.cnt = div;
            s_d.tick = 1'b1;
         end
         else
            s_d.cnt = s_q.cnt - 8'h01;
      end
      else
         s_d.pre = s_q.pre + 4'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign tick = s_q.tick;
endmodule : cssr_brg
`default_nettype wire

//--- verilog/cssr_top.sv
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cssr_top
   import cssr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   input wire logic rxd_in,
   output logic txd_out,
   output logic txd_oe,
   output logic peer_ready_out_n,
   output logic peer_ready_oe,
   output logic irq_tx,
   output logic irq_rx
);
   cssr_state_t s_q;
   cssr_state_t s_d;
   logic sclk_s;
   logic rxd_s;
   logic tick;
   logic acc;
   logic wr_ok;
   logic rd_ok;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_tbuf;
   logic wr_ireq;
   logic rd_rbuf;
   logic ext;
   logic tx_en;
   logic rx_act;
   logic rise;
   logic fall;
   logic rx_done;
   logic [7:0] rx_new;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, OFS_CTRL) | hit(a, OFS_STAT) | hit(a, OFS_TBUF) |
               hit(a, OFS_RBUF) | hit(a, OFS_BRG) | hit(a, OFS_IREQ);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and baud divider
   cssr_sync2 u_sync_sclk (
      .pclk(pclk),
      .presetn(presetn),
      .d(sclk_in),
      .q(sclk_s)
   );

   cssr_sync2 u_sync_rxd (
      .pclk(pclk),
      .presetn(presetn),
      .d(rxd_in),
      .q(rxd_s)
   );

   // divider only counts while a byte is clocked out
   cssr_brg u_brg (
      .pclk(pclk),
      .presetn(presetn),
      .en(s_q.run == RUN_SHIFT),
      .src16(s_q.ctrl[CR_SRC16]),
      .div(s_q.brg),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////
   // apb decode: one wait state, writes land on the pready edge
   assign acc = psel & penable & ~s_q.pready;
   assign wr_ok = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;
   assign rd_ok = psel & penable & s_q.pready & ~pwrite & ~s_q.pslverr;
   assign wr_ctrl = wr_ok & hit(paddr, OFS_CTRL);
   assign wr_stat = wr_ok & hit(paddr, OFS_STAT);
   assign wr_tbuf = wr_ok & hit(paddr, OFS_TBUF);
   assign wr_ireq = wr_ok & hit(paddr, OFS_IREQ);
   assign rd_rbuf = rd_ok & hit(paddr, OFS_RBUF);

   // mode decode and shift edges
   assign ext = s_q.ctrl[CR_CKS];
   assign tx_en = s_q.ctrl[CR_TXE];
   assign rx_act = s_q.ctrl[CR_RXE] & s_q.ctrl[CR_SEN];
   // R21 clock source
   always_comb
   begin
      if (ext)
      begin
         rise = sclk_s & ~s_q.sclk_d;
         fall = ~sclk_s & s_q.sclk_d;
      end
      else
      begin
         rise = tick & s_q.tph & ~s_q.sclk_o;
         fall = tick & s_q.tph & s_q.sclk_o;
      end
   end

   // R01 sample into msb
   assign rx_new = {rxd_s, s_q.rsr[7:1]};
   assign rx_done = rx_act & rise & (s_q.rcnt == RX_LAST);

   ////////////////////////////////////////////////////////////////////
   // next-state logic: bus clears first, hardware sets after, except a buffer write clears tbe after the load sets it and rdy_n after a fall sets it
   always_comb
   begin
      s_d = s_q;
      s_d.sclk_d = sclk_s;
      // bus answer
      s_d.pready = acc;
      s_d.pslverr = acc & ~mapped(paddr);
      if (acc)
      begin
         case (1'b1)
            hit(paddr, OFS_CTRL): s_d.prdata = {24'h0, s_q.ctrl};
            hit(paddr, OFS_STAT): s_d.prdata = {25'h0, s_q.sum, 2'h0,
               s_q.ovr, s_q.tsc, s_q.rbf, s_q.tbe};
            hit(paddr, OFS_RBUF): s_d.prdata = {24'h0, s_q.rbuf};
            hit(paddr, OFS_BRG): s_d.prdata = {24'h0, s_q.brg};
            hit(paddr, OFS_IREQ): s_d.prdata = {30'h0, s_q.irq_rx, s_q.irq_tx};
            default: s_d.prdata = 32'h0000_0000;
         endcase
      end
      // R04 read clears full
      if (rd_rbuf)
         s_d.rbf = 1'b0;
      // R10 status write clears overrun
      if (wr_stat)
      begin
         s_d.ovr = 1'b0;
         s_d.sum = 1'b0;
      end
      // request bits are write-one-to-clear
      if (wr_ireq & pwdata[IR_TX])
         s_d.irq_tx = 1'b0;
      if (wr_ireq & pwdata[IR_RX])
         s_d.irq_rx = 1'b0;
      if (wr_ctrl)
         s_d.ctrl = pwdata[7:0];
      if (wr_ok & hit(paddr, OFS_BRG))
         s_d.brg = pwdata[7:0];

      // internal clock: two divider ticks per phase, idles high
      if (!ext && s_q.run == RUN_SHIFT && tick)
      begin
         s_d.tph = ~s_q.tph;
         if (s_q.tph)
            s_d.sclk_o = ~s_q.sclk_o;
      end

      // transmit side; R13 runs whatever the port enable says
      if (!tx_en)
      begin
         // R12 stop and reset transmitter
         s_d.tbe = 1'b0;
         s_d.tsc = 1'b0;
         s_d.tcnt = 4'h0;
         s_d.run = RUN_IDLE;
         s_d.sclk_o = 1'b1;
         s_d.tph = 1'b0;
         if (ext & sclk_s)
            s_d.tsr = 8'h00;
      end
      else
      begin
         // R20 lsb out on falling edge
         if (fall && s_q.tcnt != BITS_BYTE)
         begin
            s_d.txd = s_q.tsr[0];
            s_d.tsr = {1'b0, s_q.tsr[7:1]};
            s_d.tcnt = s_q.tcnt + 4'h1;
            // R11 flag drops at first falling edge
            s_d.tsc = 1'b0;
         end
         // byte ends at the eighth rising edge
         if (rise && s_q.tcnt == BITS_BYTE)
         begin
            s_d.tcnt = 4'h0;
            s_d.tsc = 1'b1;
            if (s_q.ctrl[CR_TIS])
               s_d.irq_tx = 1'b1;
            // internal clock stops unless data waits
            if (s_q.tbe)
               s_d.run = RUN_IDLE;
         end
         // R09 load only while the pin clock is high
         if (!s_q.tbe && s_q.tcnt == 4'h0 && !fall && !rise && (!ext || sclk_s))
         begin
            s_d.tsr = s_q.tbuf;
            s_d.tbe = 1'b1;
            if (!s_q.ctrl[CR_TIS])
               s_d.irq_tx = 1'b1;
            if (!ext)
               s_d.run = RUN_SHIFT;
         end
      end

      // R22 ready released by first falling edge
      if (fall)
         s_d.rdy_n = 1'b1;
      if (wr_tbuf)
      begin
         s_d.tbuf = pwdata[7:0];
         s_d.tbe = 1'b0;
         if (s_q.ctrl[CR_RDYE])
            s_d.rdy_n = 1'b0;
      end

      // receive side
      if (!rx_act)
      begin
         // R14 reset shifter and flags
         s_d.rsr = 8'h00;
         s_d.rcnt = 3'h0;
         s_d.rbf = 1'b0;
         s_d.ovr = 1'b0;
         s_d.sum = 1'b0;
      end
      else if (rise)
      begin
         // R02 shift toward lsb
         s_d.rsr = rx_new;
         s_d.rcnt = s_q.rcnt + 3'h1;
         if (rx_done)
         begin
            if (s_q.rbf & ~rd_rbuf)
            begin
               // R05 overrun keeps old byte
               s_d.ovr = 1'b1;
               s_d.sum = 1'b1;
            end
            else
            begin
               // R03 move byte, then full
               s_d.rbuf = rx_new;
               s_d.rbf = 1'b1;
               // R06 receive request
               s_d.irq_rx = 1'b1;
            end
         end
      end

      if (wr_ctrl)
      begin
         // R17 enabling transmit sets both flags
         if (pwdata[CR_TXE] & ~s_q.ctrl[CR_TXE])
         begin
            s_d.tbe = 1'b1;
            s_d.tsc = 1'b1;
            s_d.irq_tx = 1'b1;
         end
         // R18 switching pins to serial raises requests
         if (pwdata[CR_SEN] & ~s_q.ctrl[CR_SEN])
         begin
            s_d.irq_tx = 1'b1;
            s_d.irq_rx = 1'b1;
         end
      end

      // pins fall back to port function when disabled
      s_d.sclk_oe = s_q.ctrl[CR_SEN] & ~ext;
      s_d.txd_oe = s_q.ctrl[CR_SEN];
      s_d.rdy_oe = s_q.ctrl[CR_SEN] & s_q.ctrl[CR_RDYE];
   end

   // R23 reset state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         s_q.brg <= BRG_RST;
         s_q.run <= RUN_IDLE;
         s_q.sclk_o <= 1'b1;
         s_q.txd <= 1'b1;
         s_q.rdy_n <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // outputs straight from the state register
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign sclk_out = s_q.sclk_o;
   assign sclk_oe = s_q.sclk_oe;
   assign txd_out = s_q.txd;
   assign txd_oe = s_q.txd_oe;
   assign peer_ready_out_n = s_q.rdy_n;
   assign peer_ready_oe = s_q.rdy_oe;
   assign irq_tx = s_q.irq_tx;
   assign irq_rx = s_q.irq_rx;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_RX_MSB: assert property (rx_act && rise |=> s_q.rsr[7] == $past(rxd_s)) // R01
      else $error("sampled bit not in msb");
   AST_RX_SHIFT: assert property (rx_act && rise |=> s_q.rsr[6:0] == $past(s_q.rsr[7:1])) // R02
      else $error("receive shift wrong");
   AST_RX_BYTE: assert property (rx_done && !s_q.rbf |=> s_q.rbf && s_q.rbuf == $past(rx_new)) // R03
      else $error("byte not buffered");
   AST_RBF_READ: assert property (rd_rbuf && !rx_done |=> !s_q.rbf) // R04
      else $error("read did not clear full");
   AST_OVERRUN: assert property (rx_done && s_q.rbf && !rd_rbuf |=> // R05
      s_q.ovr && s_q.sum && $stable(s_q.rbuf))
      else $error("overrun not flagged");
   AST_RX_IRQ: assert property ($rose(s_q.rbf) |-> s_q.irq_rx) // R06
      else $error("no receive request");
   AST_OVR_CLR: assert property (wr_stat && !rx_done |=> !s_q.ovr && !s_q.sum) // R10
      else $error("status write kept overrun");
   AST_TSC_FALL: assert property ($fell(s_q.tsc) |-> $past(fall) || $past(!tx_en)) // R11
      else $error("shift complete fell off edge");
   AST_TX_OFF: assert property (!tx_en && !wr_ctrl |=> !s_q.tbe && !s_q.tsc && s_q.sclk_o) // R12
      else $error("transmitter not reset");
   AST_RX_OFF: assert property (!rx_act |=> s_q.rsr == 8'h00 && s_q.rcnt == 3'h0 && !s_q.rbf) // R14
      else $error("receiver not reset");
   AST_TX_ON: assert property (wr_ctrl && pwdata[CR_TXE] && !tx_en |=> s_q.tbe && s_q.tsc) // R17
      else $error("enable did not set flags");
   AST_TXD_LSB: assert property (tx_en && fall && s_q.tcnt != BITS_BYTE |=> // R20
      s_q.txd == $past(s_q.tsr[0]))
      else $error("wrong transmit bit");
   AST_RDY_LOW: assert property (wr_tbuf && s_q.ctrl[CR_RDYE] |=> !s_q.rdy_n) // R22
      else $error("ready not driven low");
   AST_APB: assert property (acc |=> s_q.pready ##1 !s_q.pready)
      else $error("apb answer timing");

   COV_BYTE: cover property (rx_done && !s_q.rbf);
   COV_OVR: cover property (rx_done && s_q.rbf);
   COV_INT_RUN: cover property (s_q.run == RUN_SHIFT ##1 s_q.tsc);
   COV_RDY: cover property ($rose(s_q.rdy_n));
endmodule : cssr_top
`default_nettype wire

//--- tb/cssr_peer.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_peer
(
   input wire logic pclk,
   input wire logic sclk_pin,
   input wire logic txd,
   output logic sclk,
   output logic rxd,
   output logic [7:0] got
);
   logic [7:0] tx_q = 8'h00;
   int n = 0;

   // idle clock stands high between frames
   initial
   begin
      sclk = 1'b1;
      rxd = 1'b1;
      got = 8'h00;
   end

   ////////////////////////////////////////////////////////////
   // next bit on falling edge
   always @(negedge sclk_pin)
   begin
      rxd <= tx_q[0];
      tx_q <= tx_q >> 1;
   end

   // sample on rise; after the byte the line is let go and flips
   always @(posedge sclk_pin)
   begin
      got <= {txd, got[7:1]};
      n = n + 1;
      if (n == 8)
      begin
         n = 0;
         repeat (4) @(posedge pclk);
         rxd <= ~rxd;
      end
   end

   ////////////////////////////////////////////////////////////
   // preload the byte sent back
   task automatic load(input logic [7:0] b);
      tx_q = b;
      n = 0;
   endtask : load

   task automatic clock8(input int half);
      repeat (8)
      begin
         @(posedge pclk);
         sclk <= 1'b0;
         repeat (half) @(posedge pclk);
         sclk <= 1'b1;
         repeat (half - 1) @(posedge pclk);
      end
   endtask : clock8
endmodule : cssr_peer
`default_nettype wire

//--- tb/clock_sync_serial_receive_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_sync_serial_receive_ctrl_tb
   import cssr_pkg::*;
;
   typedef struct packed {logic [7:0] dat; logic [7:0] half; logic [31:0] st;} cssr_row_t;
   logic pclk = 1'b0;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready, pslverr, sclk_out, sclk_oe, txd_out, txd_oe;
   logic rdy_n, rdy_oe, irq_tx, irq_rx, peer_sclk, peer_rxd, e;
   logic [7:0] peer_got;
   logic [31:0] r;
   wire logic sclk_w;
   int fails = 0;
   int n_compared = 0;
   int lows;
   cssr_row_t rows [4];
   logic [7:0] clr_a [3];
   logic [31:0] clr_d [3];

   // shared clock pin: whoever enables drives it
   assign sclk_w = sclk_oe ? sclk_out : peer_sclk;
   always #5 pclk = ~pclk;

   cssr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .rxd_in(peer_rxd), .txd_out(txd_out), .txd_oe(txd_oe), .peer_ready_out_n(rdy_n),
      .peer_ready_oe(rdy_oe), .irq_tx(irq_tx), .irq_rx(irq_rx));
   cssr_peer u_peer (.pclk(pclk), .sclk_pin(sclk_w), .txd(txd_out), .sclk(peer_sclk),
      .rxd(peer_rxd), .got(peer_got));

   ////////////////////////////////////////////////////////////
   // apb master: request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: a missing answer is left to the watchdog
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk_w(input string s, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         fails++;
         $display("BAD %s exp %h got %h", s, x, g);
      end
   endtask : chk_w

   task automatic chk_b(input string s, input logic x, input logic g);
      n_compared++;
      if (g !== x)
      begin
         fails++;
         $display("BAD %s exp %b got %b", s, x, g);
      end
   endtask : chk_b

   task automatic rd(input string s, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk_w(s, x, r);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic wcyc(input int c);
      repeat (c) @(posedge pclk);
   endtask : wcyc

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////
   // hang guard, far beyond the longest sequence
   initial
   begin
      wcyc(40000);
      fails++;
      complete_run();
   end

   // main sequence
   initial
   begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      rows = '{'{8'h01, 8'h08, 32'h02}, '{8'h80, 8'h0c, 32'h02},
         '{8'ha5, 8'h09, 32'h02}, '{8'h5a, 8'h10, 32'h02}};
      clr_a = '{OFS_STAT, OFS_CTRL, OFS_CTRL};
      clr_d = '{32'h0, 32'h84, 32'h24};
      wcyc(8);
      presetn <= 1'b1;
      wcyc(1);
      chk_b("sclk_out", 1'b1, sclk_out);
      chk_b("txd_out", 1'b1, txd_out);
      chk_b("ready", 1'b1, rdy_n);
      chk_b("irq_rx", 1'b0, irq_rx);
      rd("ctrl", OFS_CTRL, 32'h0);
      rd("stat", OFS_STAT, 32'h0);
      rd("rbuf", OFS_RBUF, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk_w("unmapped", 32'h0, r);
      chk_b("slverr", 1'b1, e);
      $display("test reset done");
      // external clock receive, one row per byte
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_CTRL, 32'h0);
         wr(OFS_CTRL, 32'ha4);
         wcyc(2);
         chk_b("irq_tx", 1'b1, irq_tx);
         wr(OFS_IREQ, 32'h03);
         u_peer.load(rows[i].dat);
         u_peer.clock8(rows[i].half);
         wcyc(6);
         chk_b("irq_rx", 1'b1, irq_rx);
         rd("stat", OFS_STAT, rows[i].st);
         rd("rbuf", OFS_RBUF, {24'h0, rows[i].dat});
         rd("stat", OFS_STAT, 32'h0);
      end
      $display("test rows done");
      // overrun, then each way of clearing it
      for (int i = 0; i < 3; i++)
      begin
         wr(OFS_CTRL, 32'h0);
         wr(OFS_CTRL, 32'ha4);
         u_peer.load(8'h11);
         u_peer.clock8(8);
         wcyc(6);
         u_peer.load(8'h22);
         u_peer.clock8(8);
         wcyc(6);
         rd("stat", OFS_STAT, 32'h4a);
         rd("rbuf", OFS_RBUF, 32'h11);
         wr(clr_a[i], clr_d[i]);
         rd("stat", OFS_STAT, 32'h0);
      end
      $display("test overrun done");
      // internal clock, full duplex
      wr(OFS_CTRL, 32'h0);
      wr(OFS_BRG, 32'h0);
      wr(OFS_CTRL, 32'hb0);
      wcyc(2);
      chk_b("irq_tx", 1'b1, irq_tx);
      chk_b("sclk_oe", 1'b1, sclk_oe);
      rd("stat", OFS_STAT, 32'h05);
      wr(OFS_IREQ, 32'h03);
      u_peer.load(8'hc3);
      wr(OFS_TBUF, 32'h3c);
      lows = 0;
      for (int t = 0; t < 400 && irq_rx !== 1'b1; t++)
      begin
         @(posedge pclk);
         if (sclk_w === 1'b0)
            lows++;
      end
      wcyc(6);
      chk_w("low_cycles", 32'd64, lows);
      chk_w("peer_got", 32'h3c, {24'h0, peer_got});
      rd("stat", OFS_STAT, 32'h07);
      rd("rbuf", OFS_RBUF, 32'hc3);
      wr(OFS_CTRL, 32'h80);
      rd("stat", OFS_STAT, 32'h0);
      $display("test internal done");
      // external clock transmit with ready
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'hbc);
      wr(OFS_IREQ, 32'h03);
      u_peer.load(8'h96);
      wr(OFS_TBUF, 32'h69);
      wcyc(3);
      chk_b("ready", 1'b0, rdy_n);
      chk_b("ready_oe", 1'b1, rdy_oe);
      u_peer.clock8(8);
      wcyc(6);
      chk_b("ready", 1'b1, rdy_n);
      chk_w("peer_got", 32'h69, {24'h0, peer_got});
      rd("rbuf", OFS_RBUF, 32'h96);
      // port enable off alone: pins released, transmitter flags kept
      wr(OFS_CTRL, 32'h3c);
      wcyc(2);
      chk_b("txd_oe", 1'b0, txd_oe);
      rd("stat", OFS_STAT, 32'h05);
      $display("test external done");
      // mid-run reset clears what the last transfer left
      presetn <= 1'b0;
      wcyc(2);
      presetn <= 1'b1;
      wcyc(1);
      chk_b("irq_tx", 1'b0, irq_tx);
      rd("stat", OFS_STAT, 32'h0);
      $display("test reset again done");
      complete_run();
   end
endmodule : clock_sync_serial_receive_ctrl_tb
`default_nettype wire
